// [rtl/mtc_monitor_config.sv]
/*
 * Monitor trigger and configuration register bank: word monitor start and
 * stop control, monitor status flags, RAM double error reporting, buffer
 * rollover pointer and time tag counter.
 * Assumes all inputs but arst_n are synchronous to clk, rx_word_valid and the RAM error
 * inputs are one-cycle pulses, and the register port master never asserts
 * both strobes at once.
 */
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "mtc_map.svh"

module mtc_monitor_config #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    input  wire logic [15:0]       rx_word,
    input  wire logic              rx_word_valid,
    input  wire logic              external_trigger_input,
    input  wire logic              tag_clk_input,
    input  wire logic              ram_single_err,
    input  wire logic              ram_double_err,
    input  wire logic              buf_advance,
    output logic      [15:0]       buf_addr,
    output logic      [15:0]       time_tag,
    output logic                   monitor_active_flag,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [15:0] off);
        addr_is = (a == off[ADDR_W-1:0]);
    endfunction

    // Microseconds per tag tick for codes 0 to 5
    function automatic logic [6:0] tag_period_us(input logic [2:0] code);
        logic [6:0] slowest;
        slowest = 7'(`MTC_TAG_SLOWEST_US);
        tag_period_us = slowest >> code;
    endfunction

    function automatic logic start_source(input logic [15:0] c1);
        start_source = c1[`MTC_C1_TRIG_EN]
                       && (c1[`MTC_C1_EXT_START]
                           || c1[`MTC_C1_START_ON_TRIG]);
    endfunction

    function automatic logic mon_running(input mtc_pkg::mtc_mon_state_t m);
        mon_running = (m == mtc_pkg::MTC_MON_RUN);
    endfunction

    localparam logic [5:0] US_LAST = 6'(`MTC_US_CYCLES - 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    mtc_pkg::mtc_state_t state_reg;
    mtc_pkg::mtc_state_t state_next;

    logic       mon_enabled;
    logic       trig_en;
    logic       word_match;
    logic       ext_rise;
    logic       tag_rise;
    logic       start_cond;
    logic       stop_cond;
    logic       fire_trigger;

    logic       us_tick;
    logic       tag_inc;
    logic [2:0] tag_code;

    logic [15:0] irq_set;
    logic [15:0] cfg_one_view;

    always_comb begin
        state_next = state_reg;
        irq_set    = 16'h0000;

        // Monitor is enabled while the mode bits select monitor operation
        mon_enabled = !state_reg.cfg_one[`MTC_C1_MODE_SEL_1]
                      && state_reg.cfg_one[`MTC_C1_MODE_SEL_2];
        trig_en     = state_reg.cfg_one[`MTC_C1_TRIG_EN];
        word_match  = rx_word_valid && (rx_word == state_reg.trig_word);
        ext_rise    = external_trigger_input && !state_reg.external_trigger_input_q;
        tag_rise    = tag_clk_input && !state_reg.tag_clk_q;

        // Neither trigger source may start the monitor without enable
        start_cond = trig_en && (
            (state_reg.cfg_one[`MTC_C1_EXT_START] && ext_rise)
            || (state_reg.cfg_one[`MTC_C1_START_ON_TRIG]
                && word_match));
        stop_cond  = state_reg.cfg_one[`MTC_C1_STOP_ON_TRIG]
                     && word_match;
        fire_trigger = 1'b0;

        state_next.external_trigger_input_q = external_trigger_input;
        state_next.tag_clk_q  = tag_clk_input;

        // --------------------------------------------------------------
        // Word monitor sequencing
        // --------------------------------------------------------------
        case (state_reg.mon)
            mtc_pkg::MTC_MON_OFF: begin
                if (mon_enabled) begin
                    // Waits for a trigger only when a start source is chosen
                    if (start_source(state_reg.cfg_one)) begin
                        state_next.mon = mtc_pkg::MTC_MON_ARMED;
                    end else begin
                        state_next.mon      = mtc_pkg::MTC_MON_RUN;
                        state_next.buf_addr = 16'h0000;
                    end
                end
            end

            mtc_pkg::MTC_MON_ARMED: begin
                if (!mon_enabled) begin
                    state_next.mon = mtc_pkg::MTC_MON_OFF;
                end else if (start_cond) begin
                    state_next.mon      = mtc_pkg::MTC_MON_RUN;
                    state_next.buf_addr = 16'h0000;
                    fire_trigger        = 1'b1;
                end
            end

            mtc_pkg::MTC_MON_RUN: begin
                if (!mon_enabled) begin
                    state_next.mon = mtc_pkg::MTC_MON_OFF;
                end else if (stop_cond) begin
                    state_next.mon = mtc_pkg::MTC_MON_STOPPED;
                    fire_trigger   = 1'b1;
                    irq_set[`MTC_IRQ_STOP] =
                        state_reg.cfg_two[`MTC_C2_ENH_IRQ];
                end
            end

            mtc_pkg::MTC_MON_STOPPED: begin
                if (!mon_enabled) begin
                    state_next.mon = mtc_pkg::MTC_MON_OFF;
                end
            end

            default: begin
                state_next.mon = mtc_pkg::MTC_MON_OFF;
            end
        endcase

        // Triggered flag holds until the monitor is switched off
        if (!mon_enabled) begin
            state_next.triggered = 1'b0;
        end else if (fire_trigger) begin
            state_next.triggered = 1'b1;
        end
        // Trigger interrupts only exist with enhanced interrupts on
        irq_set[`MTC_IRQ_TRIGGER] = fire_trigger
                                    && state_reg.cfg_two[`MTC_C2_ENH_IRQ];
        if (fire_trigger) begin
            irq_set[`MTC_IRQ_TRIGGER] =
                state_reg.cfg_two[`MTC_C2_ENH_IRQ];
        end

        // --------------------------------------------------------------
        // Buffer pointer
        // --------------------------------------------------------------
        if (buf_advance && mon_running(state_reg.mon)) begin
            if (!state_reg.cfg_two[`MTC_C2_ROLLOVER]
                && state_reg.buf_addr[7:0] == `MTC_SHORT_WRAP) begin
                state_next.buf_addr = {state_reg.buf_addr[15:8], 8'h00};
            end else begin
                state_next.buf_addr = state_reg.buf_addr + 16'h0001;
            end
        end

        // --------------------------------------------------------------
        // RAM errors
        // --------------------------------------------------------------
        // Single errors are fixed by the ECC path; nothing is logged
        if (ram_double_err && state_reg.cfg_two[`MTC_C2_DBL_ERR]) begin
            irq_set[`MTC_IRQ_DBL_ERR] = 1'b1;
        end

        // --------------------------------------------------------------
        // Time tag
        // --------------------------------------------------------------
        tag_code = state_reg.cfg_two[`MTC_C2_TAG_RES_HI:`MTC_C2_TAG_RES_LO];
        us_tick  = (state_reg.cyc_cnt == US_LAST);
        state_next.cyc_cnt = us_tick ? 6'h00
                                     : state_reg.cyc_cnt + 6'h01;
        tag_inc = 1'b0;
        case (tag_code)
            `MTC_TAG_CODE_SOFT: begin
                tag_inc = reg_wr
                          && addr_is(reg_addr, `MTC_ADR_START)
                          && reg_wdata[`MTC_ST_TAG_INC];
                state_next.us_cnt = 7'h00;
            end

            `MTC_TAG_CODE_EXT: begin
                tag_inc           = tag_rise;
                state_next.us_cnt = 7'h00;
            end

            default: begin
                if (us_tick) begin
                    if (state_reg.us_cnt >= tag_period_us(tag_code) - 7'h01)
                    begin
                        state_next.us_cnt = 7'h00;
                        tag_inc           = 1'b1;
                    end else begin
                        state_next.us_cnt = state_reg.us_cnt + 7'h01;
                    end
                end
            end
        endcase
        if (tag_inc) begin
            state_next.time_tag = state_reg.time_tag + 16'h0001;
        end

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (reg_wr) begin
            if (addr_is(reg_addr, `MTC_ADR_CFG_ONE)) begin
                state_next.cfg_one = reg_wdata & `MTC_C1_WR_MASK;
            end

            if (addr_is(reg_addr, `MTC_ADR_CFG_TWO)) begin
                state_next.cfg_two = reg_wdata & `MTC_C2_WR_MASK;
            end

            if (addr_is(reg_addr, `MTC_ADR_TRIG_WORD)) begin
                state_next.trig_word = reg_wdata;
            end

            if (addr_is(reg_addr, `MTC_ADR_IRQ_MASK)) begin
                state_next.irq_mask = reg_wdata & `MTC_IRQ_IMPL_MASK;
            end

            if (addr_is(reg_addr, `MTC_ADR_TIME_TAG)) begin
                state_next.time_tag = reg_wdata;
            end
        end

        // --------------------------------------------------------------
        // Interrupt status: read clears, a new event wins
        // --------------------------------------------------------------
        if (reg_rd && addr_is(reg_addr, `MTC_ADR_IRQ_STATUS)) begin
            state_next.irq_status = irq_set;
        end else begin
            state_next.irq_status = state_reg.irq_status | irq_set;
        end

        // --------------------------------------------------------------
        // Read data, valid the cycle after the strobe only
        // --------------------------------------------------------------
        cfg_one_view = state_reg.cfg_one;
        cfg_one_view[`MTC_C1_MON_ENABLED]   = mon_enabled;
        cfg_one_view[`MTC_C1_MON_TRIGGERED] = state_reg.triggered;
        cfg_one_view[`MTC_C1_MON_ACTIVE] =
            mon_running(state_reg.mon);
        state_next.rdata = 16'h0000;
        if (reg_rd) begin
            if (addr_is(reg_addr, `MTC_ADR_CFG_ONE)) begin
                state_next.rdata = cfg_one_view;
            end else if (addr_is(reg_addr, `MTC_ADR_CFG_TWO)) begin
                state_next.rdata = state_reg.cfg_two;
            end else if (addr_is(reg_addr, `MTC_ADR_TRIG_WORD)) begin
                state_next.rdata = state_reg.trig_word;
            end else if (addr_is(reg_addr, `MTC_ADR_IRQ_MASK)) begin
                state_next.rdata = state_reg.irq_mask;
            end else if (addr_is(reg_addr, `MTC_ADR_IRQ_STATUS)) begin
                state_next.rdata = state_reg.irq_status;
            end else if (addr_is(reg_addr, `MTC_ADR_TIME_TAG)) begin
                state_next.rdata = state_reg.time_tag;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg            <= '0;
            state_reg.cfg_one    <= `MTC_C1_RESET;
            state_reg.cfg_two    <= `MTC_C2_RESET;
            state_reg.mon        <= mtc_pkg::MTC_MON_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata           = state_reg.rdata;
    assign buf_addr            = state_reg.buf_addr;
    assign time_tag            = state_reg.time_tag;
    // Decoded, not stored, so it can never disagree with the state
    assign monitor_active_flag = mon_running(state_reg.mon);
    assign irq = |(state_reg.irq_status & state_reg.irq_mask);

    // Single error input is accepted and intentionally dropped
    logic single_err_unused;
    assign single_err_unused = ram_single_err;

endmodule // mtc_monitor_config

// [shared/mtc_map.svh]
/*
 * Register offsets, field positions, reset values and timing figures of the
 * monitor trigger and configuration block.
 * Assumes a 16-bit register port and a 50 MHz system clock.
 */
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (word addresses on the register port)
// ----------------------------------------------------------------------
`define MTC_ADR_CFG_ONE        16'h0001
`define MTC_ADR_CFG_TWO        16'h0002
`define MTC_ADR_START          16'h0003
`define MTC_ADR_IRQ_MASK       16'h0004
`define MTC_ADR_IRQ_STATUS     16'h0005
`define MTC_ADR_TIME_TAG       16'h0006
`define MTC_ADR_TRIG_WORD      16'h000D

// ----------------------------------------------------------------------
// Configuration one fields
// ----------------------------------------------------------------------
`define MTC_C1_MODE_SEL_1      15
`define MTC_C1_MODE_SEL_2      14
`define MTC_C1_TRIG_EN         11
`define MTC_C1_START_ON_TRIG   10
`define MTC_C1_STOP_ON_TRIG    9
`define MTC_C1_EXT_START       7
`define MTC_C1_MON_ENABLED     2
`define MTC_C1_MON_TRIGGERED   1
`define MTC_C1_MON_ACTIVE      0
`define MTC_C1_WR_MASK         16'hFE80
`define MTC_C1_RESET           16'h8000

// ----------------------------------------------------------------------
// Configuration two fields
// ----------------------------------------------------------------------
`define MTC_C2_ENH_IRQ         15
`define MTC_C2_DBL_ERR         14
`define MTC_C2_ROLLOVER        10
`define MTC_C2_TAG_RES_HI      9
`define MTC_C2_TAG_RES_LO      7
`define MTC_C2_WR_MASK         16'hC780
`define MTC_C2_RESET           16'h0000

// ----------------------------------------------------------------------
// Start register, interrupt status and mask fields
// ----------------------------------------------------------------------
`define MTC_ST_TAG_INC         4
`define MTC_IRQ_TRIGGER        0
`define MTC_IRQ_STOP           1
`define MTC_IRQ_DBL_ERR        14
`define MTC_IRQ_IMPL_MASK      16'h4003

// ----------------------------------------------------------------------
// Time tag codes and timing
// ----------------------------------------------------------------------
`define MTC_TAG_CODE_SOFT      3'h6
`define MTC_TAG_CODE_EXT       3'h7
`define MTC_TAG_SLOWEST_US     64
`define MTC_CLK_PERIOD_NS      20
`define MTC_MICROSECOND_NS     1000
`define MTC_US_CYCLES          (`MTC_MICROSECOND_NS / `MTC_CLK_PERIOD_NS)
`define MTC_SHORT_WRAP         16'h00FF

`endif

// [shared/mtc_pkg.sv]
/*
 * Types of the monitor trigger and configuration block.
 * Assumes mtc_map.svh supplies every numeric constant.
 */
package mtc_pkg;

    // ------------------------------------------------------------------
    // Word monitor states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        MTC_MON_OFF     = 4'h1,
        MTC_MON_ARMED   = 4'h2,
        MTC_MON_RUN     = 4'h4,
        MTC_MON_STOPPED = 4'h8
    } mtc_mon_state_t;

    // ------------------------------------------------------------------
    // Register state of the block, apart from the two reset release flops
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]    cfg_one;
        logic [15:0]    cfg_two;
        logic [15:0]    trig_word;
        logic [15:0]    irq_mask;
        logic [15:0]    irq_status;
        logic [15:0]    time_tag;
        logic [5:0]     cyc_cnt;
        logic [6:0]     us_cnt;
        logic           external_trigger_input_q;
        logic           tag_clk_q;
        logic           triggered;
        mtc_mon_state_t mon;
        logic [15:0]    buf_addr;
        logic [15:0]    rdata;
    } mtc_state_t;

endpackage

// [verif/mtc_bus_model.sv]
/*
 * Far-side bus model: received words, trigger input and tag clock.
 * Assumes the bench calls its tasks and that they follow clk edges.
 */
`timescale 1ns/10ps
module mtc_bus_model (
    input  wire logic        clk,
    output logic      [15:0] rx_word,
    output logic             rx_word_valid,
    output logic             external_trigger_input,
    output logic             tag_clk_input
);
    initial begin
        rx_word = 16'hA5A5;
        rx_word_valid = 1'b0;
        external_trigger_input = 1'b0;
        tag_clk_input = 1'b0;
    end
    // Word is inverted once stale, so a match can never come from old data
    task automatic send(input logic [15:0] w);
        @(posedge clk);
        rx_word <= w;
        rx_word_valid <= 1'b1;
        @(posedge clk);
        rx_word <= ~w;
        rx_word_valid <= 1'b0;
    endtask
    task automatic ext_pulse();
        @(posedge clk) external_trigger_input <= 1'b1;
        repeat (3) @(posedge clk);
        external_trigger_input <= 1'b0;
    endtask
    // Tag clock stands low between pulses
    task automatic tag_pulse();
        @(posedge clk) tag_clk_input <= 1'b1;
        @(posedge clk) tag_clk_input <= 1'b0;
    endtask
endmodule // mtc_bus_model

// [verif/mtc_monitor_config_asserts.sv]
/*
 * Port checker of the monitor trigger and configuration block.
 * Assumes it is bound into the design and sees only its ports.
 */
`timescale 1ns/10ps
`include "mtc_map.svh"
module mtc_monitor_config_chk #(
    parameter int ADDR_W = 16
) (
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_rdata,
    input wire logic [15:0]       rx_word,
    input wire logic              rx_word_valid,
    input wire logic              external_trigger_input,
    input wire logic              tag_clk_input,
    input wire logic              ram_single_err,
    input wire logic              ram_double_err,
    input wire logic              buf_advance,
    input wire logic [15:0]       buf_addr,
    input wire logic [15:0]       time_tag,
    input wire logic              monitor_active_flag,
    input wire logic              irq
);
    // ------------------------------------------------------------------
    // Shadows of writable fields
    // ------------------------------------------------------------------
    logic [15:0] c1_reg, c2_reg, tw_reg;
    logic        m14_reg;
    logic        quiet;
    assign quiet = !rx_word_valid && !reg_wr && !external_trigger_input
                   && !irq;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            c1_reg  <= `MTC_C1_RESET;
            c2_reg  <= `MTC_C2_RESET;
            tw_reg  <= 16'h0000;
            m14_reg <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_W'(`MTC_ADR_CFG_ONE)) c1_reg <= reg_wdata;
            if (reg_addr == ADDR_W'(`MTC_ADR_CFG_TWO)) c2_reg <= reg_wdata;
            if (reg_addr == ADDR_W'(`MTC_ADR_TRIG_WORD)) tw_reg <= reg_wdata;
            if (reg_addr == ADDR_W'(`MTC_ADR_IRQ_MASK)) m14_reg <= reg_wdata[14];
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not idle");
    chk_reset_outs: assert property (disable iff (1'b0) !arst_n |->
        !monitor_active_flag && !irq && time_tag == 16'h0000
        && buf_addr == 16'h0000) else $error("outputs not cleared in reset");
    chk_single_quiet: assert property (quiet && ram_single_err
        && !ram_double_err |=> !irq) else $error("single error logged");
    chk_double_off: assert property (quiet && ram_double_err
        && !c2_reg[14] |=> !irq) else $error("double error not gated");
    chk_double_irq: assert property (ram_double_err && c2_reg[14]
        && m14_reg |=> irq) else $error("double error irq missing");
    chk_tag_soft: assert property (reg_wr && reg_wdata[4]
        && reg_addr == ADDR_W'(`MTC_ADR_START) && c2_reg[9:7] == 3'h6
        |=> time_tag == $past(time_tag) + 16'h0001)
        else $error("soft tag step wrong");
    chk_tag_ext: assert property (!reg_wr && $rose(tag_clk_input)
        && c2_reg[9:7] == 3'h7 |=> time_tag == $past(time_tag) + 16'h0001)
        else $error("tag clock step wrong");
    chk_buf_wrap: assert property (!c2_reg[10] |-> buf_addr[15:8] == 8'h00)
        else $error("buffer passed 256 words");
    chk_trig_gate: assert property ($rose(monitor_active_flag)
        && c1_reg[11] && (c1_reg[10] || c1_reg[7])
        |-> $past(external_trigger_input) || $past(rx_word_valid))
        else $error("armed monitor started without trigger");
    chk_stop_match: assert property (rx_word_valid && rx_word == tw_reg
        && c1_reg[9] && monitor_active_flag && !reg_wr
        |=> !monitor_active_flag) else $error("no stop on match");
    cover property ($rose(monitor_active_flag));
    cover property (irq ##1 !irq);
    cover property (ram_double_err && c2_reg[14]);
endmodule // mtc_monitor_config_chk

bind mtc_monitor_config mtc_monitor_config_chk #(.ADDR_W(ADDR_W)) u_chk (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .external_trigger_input(external_trigger_input),
    .tag_clk_input(tag_clk_input), .ram_single_err(ram_single_err),
    .ram_double_err(ram_double_err), .buf_advance(buf_advance),
    .buf_addr(buf_addr), .time_tag(time_tag),
    .monitor_active_flag(monitor_active_flag), .irq(irq));

// [verif/tb_top.sv]
/*
 * Bench for the monitor trigger and configuration block.
 * Assumes the design, checker bind and bus model are compiled with it.
 */
`timescale 1ns/10ps
module tb_top;
    logic        clk = 1'b0, arst_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        ram_single_err = 1'b0, ram_double_err = 1'b0;
    logic        buf_advance = 1'b0, rx_word_valid, external_trigger_input;
    logic        tag_clk_input, monitor_active_flag, irq;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, rx_word, buf_addr, time_tag;
    int          n_mismatch = 0, checked = 0, cyc = 0;
    always #10 clk = ~clk;
    mtc_monitor_config uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid),
        .external_trigger_input(external_trigger_input),
        .tag_clk_input(tag_clk_input), .ram_single_err(ram_single_err),
        .ram_double_err(ram_double_err), .buf_advance(buf_advance),
        .buf_addr(buf_addr), .time_tag(time_tag),
        .monitor_active_flag(monitor_active_flag), .irq(irq));
    mtc_bus_model bus (.clk(clk), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid),
        .external_trigger_input(external_trigger_input),
        .tag_clk_input(tag_clk_input));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Tests need about 39000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        // A real falling edge at time zero, so every reset flop sees it
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(16'h0001, 16'h8000);
        rd(16'h0002, 16'h0000);
        wr(16'h0007, 16'hFFFF);
        rd(16'h0007, 16'h0000);
        wr(16'h0001, 16'h8178);
        rd(16'h0001, 16'h8000);
        wr(16'h0002, 16'hFFFF);
        rd(16'h0002, 16'hC780);
        wr(16'h0002, 16'h8000);
        wr(16'h0004, 16'h4003);
        wr(16'h0001, 16'h4880);
        repeat (2) @(posedge clk);
        rd(16'h0001, 16'h4884);
        bus.ext_pulse();
        rd(16'h0001, 16'h4887);
        chk({15'h0000, irq}, 16'h0001);
        rd(16'h0005, 16'h0001);
        rd(16'h0005, 16'h0000);
        wr(16'h0001, 16'h8000);
        repeat (2) @(posedge clk);
        rd(16'h0001, 16'h8000);
        wr(16'h000D, 16'h1234);
        wr(16'h0001, 16'h4200);
        repeat (2) @(posedge clk);
        rd(16'h0001, 16'h4205);
        bus.send(16'h1233);
        rd(16'h0001, 16'h4205);
        bus.send(16'h1234);
        rd(16'h0001, 16'h4206);
        rd(16'h0005, 16'h0003);
        wr(16'h0002, 16'hC000);
        @(posedge clk) ram_double_err <= 1'b1;
        @(posedge clk) ram_double_err <= 1'b0;
        rd(16'h0005, 16'h4000);
        @(posedge clk) ram_single_err <= 1'b1;
        @(posedge clk) ram_single_err <= 1'b0;
        rd(16'h0005, 16'h0000);
        wr(16'h0002, 16'h8000);
        @(posedge clk) ram_double_err <= 1'b1;
        @(posedge clk) ram_double_err <= 1'b0;
        rd(16'h0005, 16'h0000);
        // Prescaler phase is unknown, so one tick either way is allowed
        for (int c = 0; c < 6; c++) begin
            wr(16'h0002, 16'h8000 | 16'(c << 7));
            wr(16'h0006, 16'h0000);
            repeat (6400) @(posedge clk);
            #1 chk(16'((time_tag + 16'h0001 - 16'(2 << c)) <= 16'h0002), 16'h0001);
        end
        wr(16'h0002, 16'h8300);
        wr(16'h0006, 16'h0000);
        wr(16'h0003, 16'h0010);
        wr(16'h0003, 16'h0010);
        #1 chk(time_tag, 16'h0002);
        wr(16'h0002, 16'h8380);
        wr(16'h0006, 16'h0000);
        repeat (3) bus.tag_pulse();
        @(posedge clk);
        #1 chk(time_tag, 16'h0003);
        wr(16'h0001, 16'h8000);
        wr(16'h0001, 16'h4C00);
        bus.send(16'h1234);
        rd(16'h0001, 16'h4C07);
        chk({15'h0000, monitor_active_flag}, 16'h0001);
        for (int r = 0; r < 2; r++) begin
            wr(16'h0002, (r == 1) ? 16'h8400 : 16'h8000);
            wr(16'h0001, 16'h8000);
            wr(16'h0001, 16'h4000);
            @(posedge clk) buf_advance <= 1'b1;
            repeat (300) @(posedge clk);
            buf_advance <= 1'b0;
            @(posedge clk);
            #1 chk(buf_addr, (r == 1) ? 16'h012C : 16'h002C);
        end
        end_sim();
    end
endmodule // tb_top
